// >>> hw/wdog_pkg.sv
// ****************************************************************
// shared constants and types for the windowed watchdog
// ****************************************************************
package wdog_pkg;

    // ************************************************************
    // register indices; byte address is four times the index
    // ************************************************************
    localparam logic [5:0] IDX_CONTROL     = 6'h08;  // watchdog_control
    localparam logic [5:0] IDX_TEST_BYPASS = 6'h09;  // factory_test_bypass
    localparam logic [5:0] IDX_TEST_CTRL   = 6'h0a;  // factory_test_control
    localparam logic [5:0] IDX_SERVICE     = 6'h0b;  // watchdog_service
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h0c;  // sticky event flags
    localparam logic [5:0] IDX_IRQ_MASK    = 6'h0d;  // event enables

    // ************************************************************
    // control field layout
    // ************************************************************
    localparam int         CTL_WINDOW_BIT = 7;       // window_mode_bit
    localparam int         CTL_DBG_BIT    = 6;       // debug_stop_bit
    localparam int         CTL_RATE_HI    = 2;       // timeout_rate_field msb
    localparam logic [2:0] RATE_OFF       = 3'h0;    // watchdog disabled

    // ************************************************************
    // service keys and reset values
    // ************************************************************
    localparam logic [7:0] KEY_FIRST      = 8'h55;
    localparam logic [7:0] KEY_SECOND     = 8'haa;
    localparam logic [7:0] TEST_BYP_RST   = 8'h00;   // reads in user mode
    localparam logic [7:0] TEST_CTL_RST   = 8'h80;   // reads in user mode

    // ************************************************************
    // time-out exponents per rate code (cycles = 2**exp)
    // ************************************************************
    localparam logic [4:0] EXP_R1 = 5'h0e;           // 2^14
    localparam logic [4:0] EXP_R2 = 5'h10;           // 2^16
    localparam logic [4:0] EXP_R3 = 5'h12;           // 2^18
    localparam logic [4:0] EXP_R4 = 5'h14;           // 2^20
    localparam logic [4:0] EXP_R5 = 5'h16;           // 2^22
    localparam logic [4:0] EXP_R6 = 5'h17;           // 2^23
    localparam logic [4:0] EXP_R7 = 5'h18;           // 2^24
    localparam int         CNT_W  = 25;              // counter width

    // ************************************************************
    // interrupt event bits
    // ************************************************************
    localparam int EV_SERVICED = 0;                  // service sequence done
    localparam int EV_WINDOW   = 1;                  // window opened
    localparam int EV_BADWRITE = 2;                  // bad or early service
    localparam int EV_TIMEOUT  = 3;                  // period expired
    localparam int EV_N        = 4;

    // ************************************************************
    // bus constants
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [7:0] UPPER_ZERO    = 8'h00;    // compare for haddr[31:24]

    // ahb-lite request bundle from the master
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_req_type;

endpackage : wdog_pkg

// >>> hw/windowed_watchdog_timer.sv
`timescale 1ns/100ps
module windowed_watchdog_timer
    import wdog_pkg::*;
(
    input  wire logic        sys_clk,        // oscillator_clock
    input  wire logic        resetn,         // system reset, active low
    input  wire ahb_req_type ahb_req,        // ahb-lite master side
    output logic             hreadyout,      // low in reset, then always ready
    output logic             hresp,          // always okay
    output logic [31:0]      hrdata,         // registered read data
    input  wire logic        special_mode,   // special operating mode
    input  wire logic        debug_mode,     // debug_mode active
    output logic             wdog_reset_req, // system reset request
    output logic             irq             // level interrupt
);

    // ************************************************************
    // bus address phase capture
    // ************************************************************
    logic       ap_valid;                    // transfer accepted now
    logic [5:0] ap_idx;                      // word index of access
    logic       ap_mapped;                   // address inside window
    logic       dp_wr_q;                     // data phase is a write
    logic [5:0] dp_idx_q;                    // index held for data phase
    logic [7:0] wdata;                       // low byte of write data

    assign ap_valid  = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == HTRANS_NONSEQ);
    assign ap_idx    = ahb_req.haddr[7:2];
    assign ap_mapped = (ahb_req.haddr[31:24] == UPPER_ZERO) && (ahb_req.haddr[23:8] == 16'h0000);
    assign wdata     = ahb_req.hwdata[7:0];

    // latch write address for the data phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dp_wr_q  <= 1'b0;
            dp_idx_q <= 6'h00;
        end else begin
            dp_wr_q  <= ap_valid && ahb_req.hwrite && ap_mapped;
            dp_idx_q <= ap_idx;
        end
    end

    // data-phase write strobes per register
    logic wr_ctl, wr_byp, wr_tctl, wr_svc, wr_sts, wr_msk;
    assign wr_ctl  = dp_wr_q && (dp_idx_q == IDX_CONTROL);
    assign wr_byp  = dp_wr_q && (dp_idx_q == IDX_TEST_BYPASS);
    assign wr_tctl = dp_wr_q && (dp_idx_q == IDX_TEST_CTRL);
    assign wr_svc  = dp_wr_q && (dp_idx_q == IDX_SERVICE);
    assign wr_sts  = dp_wr_q && (dp_idx_q == IDX_IRQ_STATUS);
    assign wr_msk  = dp_wr_q && (dp_idx_q == IDX_IRQ_MASK);

    // ************************************************************
    // control register
    // ************************************************************
    logic       window_q;                    // window_mode_bit
    logic       dbg_stop_q;                  // debug_stop_bit
    logic [2:0] rate_q;                      // timeout_rate_field
    logic       ctl_done_q;                  // window/rate written once
    logic       dbg_done_q;                  // debug bit written once
    logic       ctl_open;                    // window/rate writable now

    assign ctl_open = special_mode || !ctl_done_q;

    // write-once handling of the debug bit, and of window/rate outside special mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            window_q   <= 1'b0;
            dbg_stop_q <= 1'b0;
            rate_q     <= RATE_OFF;
            ctl_done_q <= 1'b0;
            dbg_done_q <= 1'b0;
        end else if (wr_ctl) begin
            ctl_done_q <= 1'b1;
            dbg_done_q <= 1'b1;
            if (ctl_open) begin
                window_q <= ahb_req.hwdata[CTL_WINDOW_BIT];
                rate_q   <= ahb_req.hwdata[CTL_RATE_HI:0];
            end
            if (!dbg_done_q) begin
                dbg_stop_q <= ahb_req.hwdata[CTL_DBG_BIT];
            end
        end
    end

    // a nonzero rate written while writable starts a fresh period
    logic rate_start;
    assign rate_start = wr_ctl && ctl_open && (ahb_req.hwdata[CTL_RATE_HI:0] != RATE_OFF);

    // ************************************************************
    // factory test stubs
    // ************************************************************
    logic [7:0] test_byp_q;                  // factory_test_bypass
    logic [7:0] test_ctl_q;                  // factory_test_control

    // writes only land in special mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            test_byp_q <= TEST_BYP_RST;
            test_ctl_q <= TEST_CTL_RST;
        end else begin
            if (wr_byp && special_mode) begin
                test_byp_q <= wdata;
            end
            if (wr_tctl && special_mode) begin
                test_ctl_q <= wdata;
            end
        end
    end

    // ************************************************************
    // period decode
    // ************************************************************
    logic             enabled;               // rate nonzero
    logic             frozen;                // debug freeze active
    logic [4:0]       exp_sel;               // period exponent
    logic [CNT_W-1:0] period;                // cycles per period
    logic [CNT_W-1:0] last_cnt;              // final count of period
    logic [CNT_W-1:0] win_start;             // first count in window

    assign enabled = (rate_q != RATE_OFF);
    assign frozen  = dbg_stop_q && debug_mode;

    // rate code to exponent
    always_comb begin
        unique case (rate_q)
            3'h1:    exp_sel = EXP_R1;
            3'h2:    exp_sel = EXP_R2;
            3'h3:    exp_sel = EXP_R3;
            3'h4:    exp_sel = EXP_R4;
            3'h5:    exp_sel = EXP_R5;
            3'h6:    exp_sel = EXP_R6;
            3'h7:    exp_sel = EXP_R7;
            default: exp_sel = EXP_R7;
        endcase
    end

    assign period    = {{(CNT_W-1){1'b0}}, 1'b1} << exp_sel;
    assign last_cnt  = period - {{(CNT_W-1){1'b0}}, 1'b1};
    assign win_start = period - (period >> 2);

    // ************************************************************
    // counter and service sequence
    // ************************************************************
    logic [CNT_W-1:0] cnt_q;                 // cycles since restart
    logic             armed_q;               // first key seen
    logic             win_open;              // last quarter reached
    logic             expire;                // final cycle counted
    logic             svc_live;              // service write counts
    logic             svc_bad;               // illegal service write
    logic             svc_done;              // sequence completed

    assign win_open = (cnt_q >= win_start);
    assign expire   = enabled && !frozen && (cnt_q == last_cnt);
    assign svc_live = wr_svc && enabled;
    assign svc_bad  = svc_live && (((wdata != KEY_FIRST) && (wdata != KEY_SECOND))
                      || (window_q && !win_open));
    assign svc_done = svc_live && !svc_bad && (wdata == KEY_SECOND) && armed_q;

    // counter restarts on service, timeout, or new rate
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (!enabled || rate_start || svc_done || expire || svc_bad) begin
            cnt_q <= '0;
        end else if (!frozen) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // key sequence tracker; repeats of either key are harmless outside window mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else if (!enabled || svc_bad || svc_done || rate_start || expire) begin
            armed_q <= 1'b0;
        end else if (svc_live && (wdata == KEY_FIRST)) begin
            armed_q <= 1'b1;
        end
    end

    // system reset request, one cycle wide
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wdog_reset_req <= 1'b0;
        end else begin
            wdog_reset_req <= expire || svc_bad;
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    logic [EV_N-1:0] ev;                     // event pulses
    logic [EV_N-1:0] sts_q;                  // sticky status
    logic [EV_N-1:0] msk_q;                  // interrupt enables
    logic            win_open_q;             // delayed window flag

    // window edge detect
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            win_open_q <= 1'b0;
        end else begin
            win_open_q <= win_open && enabled;
        end
    end

    assign ev[EV_SERVICED] = svc_done;
    assign ev[EV_WINDOW]   = win_open && enabled && !win_open_q;
    assign ev[EV_BADWRITE] = svc_bad;
    assign ev[EV_TIMEOUT]  = expire;

    // per bit: set wins over write-one-to-clear
    for (genvar i = 0; i < EV_N; i++) begin : g_sts
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                sts_q[i] <= 1'b0;
            end else if (ev[i]) begin
                sts_q[i] <= 1'b1;
            end else if (wr_sts && ahb_req.hwdata[i]) begin
                sts_q[i] <= 1'b0;
            end
        end
    end

    // mask register and interrupt line
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            msk_q <= '0;
            irq   <= 1'b0;
        end else begin
            if (wr_msk) begin
                msk_q <= ahb_req.hwdata[EV_N-1:0];
            end
            irq <= |(sts_q & msk_q);
        end
    end

    // ************************************************************
    // read path and bus response
    // ************************************************************
    logic [31:0] rd_mux;                     // selected read value

    // read decode, unmapped reads give zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ap_mapped) begin
            unique case (ap_idx)
                IDX_CONTROL:     rd_mux = {24'h000000, window_q, dbg_stop_q, 3'h0, rate_q};
                IDX_TEST_BYPASS: rd_mux = {24'h000000, special_mode ? test_byp_q : TEST_BYP_RST};
                IDX_TEST_CTRL:   rd_mux = {24'h000000, special_mode ? test_ctl_q : TEST_CTL_RST};
                IDX_SERVICE:     rd_mux = 32'h0000_0000;
                IDX_IRQ_STATUS:  rd_mux = {28'h0000000, sts_q};
                IDX_IRQ_MASK:    rd_mux = {28'h0000000, msk_q};
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // read data registered at the address phase edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_valid && !ahb_req.hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    early_write_reset_a: assert property (
        (wr_svc && enabled && window_q && !win_open) |=> wdog_reset_req)
        else $error("early service write did not reset");

    window_key_ok_a: assert property (
        (wr_svc && enabled && window_q && win_open && !expire && (wdata == KEY_FIRST)) |=> !wdog_reset_req)
        else $error("first key inside window reset the part");

    disabled_ignore_a: assert property (
        (wr_svc && !enabled && !expire) |=> !wdog_reset_req)
        else $error("service write while disabled had effect");

    bad_key_reset_a: assert property (
        (wr_svc && enabled && (wdata != KEY_FIRST) && (wdata != KEY_SECOND)) |=> wdog_reset_req)
        else $error("bad service value did not reset");

    sequence_restart_a: assert property (
        (wr_svc && enabled && armed_q && (wdata == KEY_SECOND) && !(window_q && !win_open))
        |=> (cnt_q == '0) ##1 !win_open)
        else $error("key sequence did not restart period");

    debug_freeze_a: assert property (
        (frozen && $stable(rate_q) && !wr_svc && !wr_ctl && enabled) |=> $stable(cnt_q))
        else $error("counter moved while frozen");

    timeout_reset_a: assert property (
        (enabled && !frozen && cnt_q == last_cnt) |=> wdog_reset_req ##0 (cnt_q == '0))
        else $error("expiry did not reset");

    reset_pulse_a: assert property (
        $rose(wdog_reset_req) |=> !wdog_reset_req || $past(expire) || $past(svc_bad))
        else $error("reset request not tied to a cause");

    service_read_a: assert property (
        (ap_valid && !ahb_req.hwrite && ap_idx == IDX_SERVICE) |=> (hrdata == 32'h0000_0000))
        else $error("service register read nonzero");

    test_user_read_a: assert property (
        (ap_valid && !ahb_req.hwrite && ap_mapped && ap_idx == IDX_TEST_CTRL && !special_mode)
        |=> (hrdata == {24'h000000, TEST_CTL_RST}))
        else $error("test control misread in user mode");

    // ************************************************************
    // further checks: write-once control, stubs, reset cause
    // ************************************************************

    // user mode refuses a second window or rate write
    ctl_once_a: assert property (
        (wr_ctl && !special_mode && ctl_done_q) |=> ($stable(rate_q) && $stable(window_q)))
        else $error("control rewritten in user mode");

    // debug bit takes only its first write
    dbg_once_a: assert property (
        (wr_ctl && dbg_done_q) |=> $stable(dbg_stop_q))
        else $error("debug stop bit rewritten");

    // accepted nonzero rate begins a fresh period
    rate_start_a: assert property (
        (wr_ctl && ctl_open && (ahb_req.hwdata[CTL_RATE_HI:0] != RATE_OFF))
        |=> (enabled && (cnt_q == '0)))
        else $error("rate write did not start a period");

    // disabled counter rests at zero
    off_hold_a: assert property (
        !enabled |=> (cnt_q == '0))
        else $error("counter ran while disabled");

    // key values outside window mode never reset
    repeat_key_a: assert property (
        (wr_svc && enabled && !window_q && !expire && ((wdata == KEY_FIRST) || (wdata == KEY_SECOND)))
        |=> !wdog_reset_req)
        else $error("key write reset the part");

    // bypass stub reads its reset value in user mode
    byp_user_read_a: assert property (
        (ap_valid && !ahb_req.hwrite && ap_mapped && ap_idx == IDX_TEST_BYPASS && !special_mode)
        |=> (hrdata == {24'h000000, TEST_BYP_RST}))
        else $error("test bypass misread in user mode");

    // every request cycle has a cause one edge before
    req_cause_a: assert property (
        wdog_reset_req |-> ($past(expire) || $past(svc_bad)))
        else $error("reset request without a cause");

endmodule : windowed_watchdog_timer

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import wdog_pkg::*;
;
    // ********************************************************
    // bench signals
    // ********************************************************
    logic             sys_clk;         // 250 mhz clock
    logic             resetn;          // active low reset
    logic             special_mode;    // special mode level
    logic             debug_mode;      // debug active level
    logic             hsel;            // bus select
    logic             hwrite;          // bus direction
    logic [1:0]       htrans;          // bus transfer kind
    logic [2:0]       hsize;           // bus size
    logic [31:0]      haddr;           // bus address
    logic [31:0]      hwdata;          // bus write data
    ahb_req_type      ahb_req;         // bundled request
    logic             hreadyout;       // slave ready
    logic             hresp;           // slave response
    logic [31:0]      hrdata;          // slave read data
    logic             wdog_reset_req;  // reset request pulse
    logic             irq;             // interrupt level
    logic [31:0]      pulse_cnt;       // cycles with reset request high
    logic [31:0]      rdat;            // last read data
    int               error_cnt;       // mismatches
    int               comparisons;     // compares made

    // single slave: its ready is the bus ready
    assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                       hsize: hsize, hwdata: hwdata, hready: hreadyout};

    windowed_watchdog_timer dut (
        .sys_clk        (sys_clk),
        .resetn         (resetn),
        .ahb_req        (ahb_req),
        .hreadyout      (hreadyout),
        .hresp          (hresp),
        .hrdata         (hrdata),
        .special_mode   (special_mode),
        .debug_mode     (debug_mode),
        .wdog_reset_req (wdog_reset_req),
        .irq            (irq)
    );

    // ********************************************************
    // clock, reset request monitor, hang guard
    // ********************************************************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // counts every cycle the reset request stands high
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt <= 32'h0;
        end else if (wdog_reset_req === 1'b1) begin
            pulse_cnt <= pulse_cnt + 32'h1;
        end
    end

    // whole run needs about 50k cycles
    initial begin
        repeat (80000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [31:0] adr(input logic [5:0] idx);
        return {24'h000000, idx, 2'h0};
    endfunction : adr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one single transfer; holds each phase until ready is sampled high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, adr(idx), {24'h000000, d});
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ********************************************************
    // test sequence
    // ********************************************************
    initial begin
        resetn = 1'b0;
        special_mode = 1'b0;
        debug_mode = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        error_cnt = 0;
        comparisons = 0;
        idle(12);
        resetn <= 1'b1;
        idle(2);
        // reset values, test registers in user mode, unmapped place
        rd(adr(IDX_CONTROL), 32'h0);
        rd(adr(IDX_SERVICE), 32'h0);
        wr(IDX_TEST_BYPASS, 8'h5a);
        rd(adr(IDX_TEST_BYPASS), {24'h0, TEST_BYP_RST});
        wr(IDX_TEST_CTRL, 8'h11);
        rd(adr(IDX_TEST_CTRL), {24'h0, TEST_CTL_RST});
        rd(32'h0000003c, 32'h0);
        // disabled: a bad key does nothing
        wr(IDX_SERVICE, 8'h13);
        idle(3);
        chk(pulse_cnt, 32'h0);
        // first control write sticks, second is refused in user mode
        wr(IDX_CONTROL, 8'h41);
        wr(IDX_CONTROL, 8'h07);
        rd(adr(IDX_CONTROL), 32'h41);
        // repeated keys then repeated second key
        wr(IDX_SERVICE, KEY_FIRST);
        wr(IDX_SERVICE, KEY_FIRST);
        wr(IDX_SERVICE, KEY_SECOND);
        wr(IDX_SERVICE, KEY_SECOND);
        idle(3);
        chk(pulse_cnt, 32'h0);
        // frozen in debug beyond a whole period
        debug_mode <= 1'b1;
        idle(20000);
        chk(pulse_cnt, 32'h0);
        debug_mode <= 1'b0;
        // time-out measured from the last restart
        wr(IDX_SERVICE, KEY_FIRST);
        wr(IDX_SERVICE, KEY_SECOND);
        idle(16300);
        chk(pulse_cnt, 32'h0);
        idle(200);
        chk(pulse_cnt, 32'h1);
        // bad key raises a masked-in interrupt
        rd(adr(IDX_IRQ_STATUS), 32'h0000000b);
        wr(IDX_IRQ_STATUS, 8'h0f);
        wr(IDX_IRQ_MASK, 8'h04);
        wr(IDX_SERVICE, 8'h12);
        idle(3);
        chk(pulse_cnt, 32'h2);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, adr(IDX_IRQ_STATUS), 32'h0);
        chk(rdat & 32'h4, 32'h4);
        wr(IDX_IRQ_STATUS, 8'h0f);
        idle(3);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_SERVICE, 8'h00);
        idle(3);
        chk(pulse_cnt, 32'h3);
        chk({31'h0, irq}, 32'h0);
        // special mode: window on, debug bit stays once-only
        special_mode <= 1'b1;
        wr(IDX_CONTROL, 8'h81);
        rd(adr(IDX_CONTROL), 32'hc1);
        wr(IDX_SERVICE, KEY_FIRST);
        idle(3);
        chk(pulse_cnt, 32'h4);
        idle(12300);
        wr(IDX_SERVICE, KEY_FIRST);
        wr(IDX_SERVICE, KEY_FIRST);
        wr(IDX_SERVICE, KEY_SECOND);
        idle(3);
        chk(pulse_cnt, 32'h4);
        wr(IDX_SERVICE, KEY_FIRST);
        idle(3);
        chk(pulse_cnt, 32'h5);
        end_sim();
    end

endmodule : tb_top
